/* dv/chb_node_model.sv */
// Remote node model that sends heartbeat frames into the block
`timescale 1ns/100ps
`default_nettype none
module chb_node_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Bench control
    input  wire logic       send,
    input  wire logic [7:0] node,
    input  wire logic [6:0] state,
    // Heartbeat toward the block
    output logic            hbRxValid,
    output logic [7:0]      hbRxNode,
    output logic [6:0]      hbRxState
);
    // Idle lines toggle so stale values are never mistaken for a frame
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hbRxValid <= 1'b0;
            hbRxNode  <= 8'h00;
            hbRxState <= 7'h00;
        end else begin
            hbRxValid <= send;
            hbRxNode  <= send ? node : ~hbRxNode;
            hbRxState <= send ? state : ~hbRxState;
        end
    end
endmodule : chb_node_model
`default_nettype wire

/* dv/tb_chb_objects.sv */
// Self-checking bench for the communication-object services block
`timescale 1ns/100ps
`default_nettype none
module tb_chb_objects;
    import chb_pkg::*;
    localparam logic [31:0] VENDOR = 32'h0000_0a5a; // arbitrary
    logic        clk = 1'b0, rstn = 1'b0, nmtPreOp = 1'b1, send = 1'b0;
    logic        syncProducer = 1'b0, emcyReq = 1'b0, dictReq = 1'b0;
    logic        dictWe = 1'b0;
    logic [15:0] dictIndex = 16'h0;
    logic [7:0]  dictSub = 8'h0;
    logic [31:0] dictWdata = 32'h0;
    logic        dictAck, dictErr, syncTx, emcyTx, hbTx, hbRxValid, timeConsume;
    logic        syncRx = 1'b0, syncWindowOpen, emcyExtended;
    logic [28:0] emcyCobId;
    logic [7:0]  hbTimeout;
    logic [31:0] dictRdata, timeStamp;
    logic [7:0]  hbRxNode, hbChanged;
    logic [6:0]  hbRxState;
    int          n_mismatch = 0, num_checks = 0, n;
    chb_objects #(.VENDOR_CODE(VENDOR)) u_chb_objects (
        .clk(clk), .rstn(rstn), .nodeId(7'h05), .nmtPreOp(nmtPreOp),
        .syncProducer(syncProducer), .dictReq(dictReq), .dictWe(dictWe),
        .dictIndex(dictIndex), .dictSub(dictSub), .dictWdata(dictWdata),
        .dictAck(dictAck), .dictErr(dictErr), .dictRdata(dictRdata),
        .syncRx(syncRx), .emcyReq(emcyReq), .hbRxValid(hbRxValid),
        .hbRxNode(hbRxNode), .hbRxState(hbRxState), .syncTx(syncTx),
        .syncWindowOpen(syncWindowOpen), .emcyTx(emcyTx),
        .emcyExtended(emcyExtended), .emcyCobId(emcyCobId),
        .timeConsume(timeConsume), .hbTx(hbTx), .hbChanged(hbChanged),
        .hbTimeout(hbTimeout), .timeStamp(timeStamp));
    chb_node_model u_chb_node_model (.clk(clk), .rstn(rstn), .send(send),
        .node(8'h05), .state(7'h05), .hbRxValid(hbRxValid),
        .hbRxNode(hbRxNode), .hbRxState(hbRxState));
    always #20 clk = ~clk;
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s,
                       input logic [31:0] d, input logic er,
                       input logic [31:0] rd);
        @(posedge clk);
        dictReq   <= 1'b1;
        dictWe    <= w;
        dictIndex <= i;
        dictSub   <= s;
        dictWdata <= d;
        @(posedge clk);
        dictReq <= 1'b0;
        #1;
        chk({30'h0, dictAck, dictErr}, {30'h0, 1'b1, er});
        if (!er && !w)
            chk(dictRdata, rd);
    endtask : acc
    task automatic wait_sync(output int c);
        c = 0;
        do begin
            @(posedge clk);
            #1;
            c++;
        end while (syncTx !== 1'b1 && c < 4000);
    endtask : wait_sync
    task automatic emcy_count(output int c);
        c = 0;
        @(posedge clk);
        emcyReq <= 1'b1;
        @(posedge clk);
        emcyReq <= 1'b0;
        repeat (6) begin
            @(posedge clk);
            #1;
            if (emcyTx === 1'b1)
                c++;
        end
    endtask : emcy_count
    task automatic t_defaults;
        chk({16'h0, timeStamp[31:16]}, 32'h0);
        acc(1'b0, IDX_GUARD_TIME, 8'h0, 32'h0, 1'b0, 32'h0);
        acc(1'b0, IDX_LIFE_FACTOR, 8'h0, 32'h0, 1'b0, 32'h0);
        acc(1'b1, IDX_GUARD_TIME, 8'h0, 32'h1, 1'b1, 32'h0);
        acc(1'b0, IDX_TIME_ID, 8'h0, 32'h0, 1'b0, TIME_ID_RESET);
        acc(1'b0, IDX_EMCY_ID, 8'h0, 32'h0, 1'b0, 32'h85);
        acc(1'b0, IDX_HB_MONITOR, 8'h0, 32'h0, 1'b0, 32'h8);
        acc(1'b0, IDX_IDENTITY, 8'h1, 32'h0, 1'b0, VENDOR);
        acc(1'b1, IDX_IDENTITY, 8'h1, 32'h0, 1'b1, 32'h0);
        acc(1'b0, 16'h1019, 8'h0, 32'h0, 1'b1, 32'h0);
        chk({2'b0, emcyExtended, emcyCobId}, 32'h85);
    endtask : t_defaults
    task automatic t_config;
        @(posedge clk);
        nmtPreOp <= 1'b0;
        acc(1'b1, IDX_SYNC_PERIOD, 8'h0, 32'h1, 1'b1, 32'h0);
        @(posedge clk);
        nmtPreOp <= 1'b1;
        acc(1'b1, IDX_SYNC_WINDOW, 8'h0, PERIOD_MAX_US + 32'h1, 1'b1, 32'h0);
        acc(1'b1, IDX_TIME_ID, 8'h0, 32'h4000_0100, 1'b1, 32'h0);
        acc(1'b1, IDX_TIME_ID, 8'h0, 32'h8000_0100, 1'b0, 32'h0);
        @(posedge clk);
        #1;
        chk({31'h0, timeConsume}, 32'h1);
        acc(1'b1, IDX_TIME_STAMP, 8'h0, 32'h4000_0000, 1'b0, 32'h0);
        @(posedge clk);
        #1;
        chk({16'h0, timeStamp[31:16]}, 32'h4000);
        acc(1'b1, IDX_TIME_STAMP, 8'h0, 32'h4000_0020, 1'b0, 32'h0);
        chk({4'h0, timeStamp[31:4]}, 32'h0400_0000);
        // Let the trim run out before any tick-exact timing
        repeat (1000) @(posedge clk);
    endtask : t_config
    task automatic hb_pulse;
        @(posedge clk);
        send <= 1'b1;
        @(posedge clk);
        send <= 1'b0;
        @(posedge clk);
        #1;
    endtask : hb_pulse
    task automatic t_heartbeat;
        acc(1'b1, IDX_HB_MONITOR, 8'h1, 32'h0005_0000, 1'b0, 32'h0);
        acc(1'b1, IDX_HB_MONITOR, 8'h2, 32'h0005_0000, 1'b1, 32'h0);
        acc(1'b1, IDX_HB_MONITOR, 8'h1, 32'h0005_0000, 1'b0, 32'h0);
        hb_pulse;
        chk({24'h0, hbChanged}, 32'h1);
        acc(1'b1, IDX_HB_PRODUCER, 8'h0, 32'h1, 1'b0, 32'h0);
        chk({31'h0, hbTx}, 32'h1);
        acc(1'b1, IDX_HB_PRODUCER, 8'h0, 32'h0, 1'b0, 32'h0);
        acc(1'b1, IDX_HB_MONITOR, 8'h1, 32'h0005_0001, 1'b0, 32'h0);
        hb_pulse;
        chk({24'h0, hbChanged}, 32'h0);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (hbTimeout[0] !== 1'b1 && n < 26000);
        chk({31'h0, hbTimeout[0]}, 32'h1);
    endtask : t_heartbeat
    task automatic t_emcy;
        acc(1'b1, IDX_EMCY_INHIB, 8'h0, 32'h2, 1'b0, 32'h0);
        emcy_count(n);
        chk(32'(n), 32'h1);
        emcy_count(n);
        chk(32'(n), 32'h0);
        acc(1'b1, IDX_EMCY_ID, 8'h0, 32'h8000_0085, 1'b0, 32'h0);
        acc(1'b1, IDX_EMCY_INHIB, 8'h0, 32'h0, 1'b0, 32'h0);
        emcy_count(n);
        chk(32'(n), 32'h0);
        acc(1'b1, IDX_EMCY_ID, 8'h0, 32'h4000_0085, 1'b1, 32'h0);
        acc(1'b1, IDX_EMCY_ID, 8'h0, 32'ha000_0123, 1'b0, 32'h0);
        @(posedge clk);
        #1;
        chk({2'b0, emcyExtended, emcyCobId}, 32'h2000_0123);
    endtask : t_emcy
    task automatic t_sync;
        acc(1'b1, IDX_SYNC_PERIOD, 8'h0, 32'h1, 1'b0, 32'h0);
        acc(1'b1, IDX_SYNC_WINDOW, 8'h0, 32'h1, 1'b0, 32'h0);
        @(posedge clk);
        syncRx <= 1'b1;
        @(posedge clk);
        syncRx <= 1'b0;
        @(posedge clk);
        #1;
        chk({31'h0, syncWindowOpen}, 32'h1);
        @(posedge clk);
        syncProducer <= 1'b1;
        wait_sync(n);
        wait_sync(n);
        chk(32'(n), 32'(SYNC_QUANT_US * CYC_PER_US));
        chk({31'h0, syncWindowOpen}, 32'h1);
        acc(1'b1, IDX_SYNC_PERIOD, 8'h0, 32'h0, 1'b0, 32'h0);
        wait_sync(n);
        chk(32'(n), 32'hfa0);
        chk({31'h0, syncWindowOpen}, 32'h0);
    endtask : t_sync
    task automatic complete_run;
        if (n_mismatch == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    initial begin
        #(40 * 60000);
        n_mismatch++;
        complete_run;
    end
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        t_defaults;
        t_config;
        t_heartbeat;
        t_emcy;
        t_sync;
        complete_run;
    end
endmodule : tb_chb_objects
`default_nettype wire

/* hw/chb_objects.sv */
// Sync, time stamp, emergency and heartbeat communication objects
`timescale 1ns/100ps
`default_nettype none
module chb_objects
    import chb_pkg::*;
#(
    parameter int          MONITORS     = 8,
    parameter logic [31:0] VENDOR_CODE  = 32'h0000_0a5a, // arbitrary
    parameter logic [31:0] PRODUCT_CODE = 32'h0000_0001, // arbitrary
    parameter logic [31:0] REVISION     = 32'h0001_0000, // arbitrary
    parameter logic [31:0] SERIAL       = 32'h0000_0001  // arbitrary
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Node context
    input  wire logic [6:0]  nodeId,
    input  wire logic        nmtPreOp,
    input  wire logic        syncProducer,
    // Dictionary access
    input  wire logic        dictReq,
    input  wire logic        dictWe,
    input  wire logic [15:0] dictIndex,
    input  wire logic [7:0]  dictSub,
    input  wire logic [31:0] dictWdata,
    output logic             dictAck,
    output logic             dictErr,
    output logic [31:0]      dictRdata,
    // Frame events
    input  wire logic        syncRx,
    input  wire logic        emcyReq,
    input  wire logic        hbRxValid,
    input  wire logic [7:0]  hbRxNode,
    input  wire logic [6:0]  hbRxState,
    output logic             syncTx,
    output logic             syncWindowOpen,
    output logic             emcyTx,
    output logic             emcyExtended,
    output logic [28:0]      emcyCobId,
    output logic             timeConsume,
    output logic             hbTx,
    // Monitor results and time stamp
    output logic [MONITORS-1:0] hbChanged,
    output logic [MONITORS-1:0] hbTimeout,
    output logic [31:0]      timeStamp
);
    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (MONITORS != int'(HB_MONITOR_NUM)) begin : g_bad
        $error("MONITORS must match the monitor array size");
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [31:0] syncPeriod, syncWindow, timeId, emcyIdReg;
    logic [31:0] emcyInhibit, emcyGap;
    logic        emcyIdSet, emcyPend;
    logic [15:0] hbPeriod, hbCount;
    logic [4:0]  cyc;
    logic [6:0]  usInUnit, usInHundred;
    logic [9:0]  usInMs;
    logic [22:0] accum;
    logic signed [31:0] trim;
    logic [31:0] hbEntry [MONITORS];
    logic [15:0] hbTimer [MONITORS];
    logic [6:0]  hbState [MONITORS];
    chb_monitor_type hbMon [MONITORS];

    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------
    function automatic logic isIdx(input logic [15:0] idx);
        return dictIndex == idx;
    endfunction : isIdx

    wire         wr        = dictReq && dictWe;
    wire         subZero   = dictSub == 8'h00;
    wire         isHbEntry = isIdx(IDX_HB_MONITOR) && subZero == 1'b0
                             && dictSub <= HB_MONITOR_NUM;
    wire         isIdent   = isIdx(IDX_IDENTITY) && dictSub <= IDENTITY_NUM;
    wire         simpleObj = subZero && (isIdx(IDX_SYNC_PERIOD)
                             || isIdx(IDX_SYNC_WINDOW)
                             || isIdx(IDX_GUARD_TIME)
                             || isIdx(IDX_LIFE_FACTOR)
                             || isIdx(IDX_TIME_ID)
                             || isIdx(IDX_TIME_STAMP)
                             || isIdx(IDX_EMCY_ID)
                             || isIdx(IDX_EMCY_INHIB)
                             || isIdx(IDX_HB_PRODUCER));
    wire         mapped    = simpleObj || isIdent
                             || isIdx(IDX_HB_MONITOR) && isHbEntry
                             || isIdx(IDX_HB_MONITOR) && subZero;
    wire         readOnly  = isIdx(IDX_GUARD_TIME)
                             || isIdx(IDX_LIFE_FACTOR)
                             || isIdx(IDX_IDENTITY)
                             || isIdx(IDX_HB_MONITOR) && subZero;
    wire         preOpOnly = isIdx(IDX_SYNC_PERIOD)
                             || isIdx(IDX_SYNC_WINDOW)
                             || isIdx(IDX_TIME_ID)
                             || isIdx(IDX_HB_MONITOR)
                             || isIdx(IDX_HB_PRODUCER);
    wire [2:0]   hbSel     = 3'(dictSub - 8'h01);
    wire [7:0]   wNode     = dictWdata[23:16];
    logic [MONITORS-1:0] dupHit;
    wire         overMax   = (isIdx(IDX_SYNC_PERIOD)
                             || isIdx(IDX_SYNC_WINDOW))
                             && dictWdata > PERIOD_MAX_US;
    wire         badBit30  = (isIdx(IDX_TIME_ID) || isIdx(IDX_EMCY_ID))
                             && dictWdata[BIT_PRODUCER];
    wire         wrFault   = !mapped || readOnly
                             || preOpOnly && !nmtPreOp
                             || overMax || badBit30
                             || isHbEntry && |dupHit;
    wire         wrOk      = wr && !wrFault;
    wire         rdFault   = dictReq && !dictWe && !mapped;

    wire [31:0]  emcyId    = emcyIdSet ? emcyIdReg
                             : {24'h0, EMCY_ID_BASE} + {25'h0, nodeId};

    logic [31:0] readValue;
    always_comb begin
        readValue = 32'h0;
        case (dictIndex)
            IDX_SYNC_PERIOD: readValue = syncPeriod;
            IDX_SYNC_WINDOW: readValue = syncWindow;
            IDX_TIME_ID:     readValue = timeId;
            IDX_TIME_STAMP:  readValue = timeStamp;
            IDX_EMCY_ID:     readValue = emcyId;
            IDX_EMCY_INHIB:  readValue = emcyInhibit;
            IDX_HB_PRODUCER: readValue = {16'h0, hbPeriod};
            IDX_HB_MONITOR:  readValue = subZero ? {24'h0, HB_MONITOR_NUM}
                                         : hbEntry[hbSel];
            IDX_IDENTITY: begin
                case (dictSub)
                    8'h00:   readValue = {24'h0, IDENTITY_NUM};
                    8'h01:   readValue = VENDOR_CODE;
                    8'h02:   readValue = PRODUCT_CODE;
                    8'h03:   readValue = REVISION;
                    8'h04:   readValue = SERIAL;
                    default: readValue = 32'h0;
                endcase
            end
            default:         readValue = 32'h0;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dictAck   <= 1'b0;
            dictErr   <= 1'b0;
            dictRdata <= 32'h0;
        end else begin
            dictAck   <= dictReq;
            dictErr   <= wr && wrFault || rdFault;
            dictRdata <= (dictReq && !dictWe && mapped) ? readValue : 32'h0;
        end
    end

    // ------------------------------------------------------------
    // Configuration writes
    // ------------------------------------------------------------
    function automatic logic wrTo(input logic [15:0] idx);
        return wrOk && isIdx(idx);
    endfunction : wrTo

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            syncPeriod  <= 32'h0;
            syncWindow  <= 32'h0;
            timeId      <= TIME_ID_RESET;
            emcyIdReg   <= 32'h0;
            emcyIdSet   <= 1'b0;
            emcyInhibit <= 32'h0;
            hbPeriod    <= 16'h0;
        end else begin
            if (wrTo(IDX_SYNC_PERIOD)) syncPeriod  <= dictWdata;
            if (wrTo(IDX_SYNC_WINDOW)) syncWindow  <= dictWdata;
            if (wrTo(IDX_TIME_ID))     timeId      <= dictWdata;
            if (wrTo(IDX_EMCY_INHIB))  emcyInhibit <= dictWdata;
            if (wrTo(IDX_HB_PRODUCER)) hbPeriod    <= dictWdata[15:0];
            if (wrTo(IDX_EMCY_ID)) begin
                emcyIdReg <= dictWdata;
                emcyIdSet <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Microsecond tick with trim, time stamp
    // ------------------------------------------------------------
    wire        tsWrite = wrTo(IDX_TIME_STAMP);
    wire [31:0] tsDiff  = dictWdata - timeStamp;
    wire [31:0] tsMag   = tsDiff[31] ? (~tsDiff + 32'h1) : tsDiff;
    wire        tsSmall = tsMag <= TRIM_LIMIT_US;
    wire [4:0]  tickLen = (trim > 0) ? 5'(CYC_PER_US - 2)
                          : (trim < 0) ? 5'(CYC_PER_US)
                          : 5'(CYC_PER_US - 1);
    // Compare by range so a shorter tick never lets cyc run past its end
    wire        usTick  = cyc >= tickLen;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cyc       <= 5'h0;
            trim      <= 32'sh0;
            timeStamp <= 32'h0;
        end else begin
            cyc <= usTick ? 5'h0 : cyc + 5'h1;
            if (tsWrite && tsSmall) begin
                trim <= signed'(tsDiff);
            end else if (usTick && trim != 0) begin
                trim <= (trim > 0) ? trim - 32'sh1 : trim + 32'sh1;
            end
            if (tsWrite && !tsSmall) begin
                timeStamp <= dictWdata;
            end else if (usTick) begin
                timeStamp <= timeStamp + 32'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Coarse time bases: 120 us, 100 us, 1 ms
    // ------------------------------------------------------------
    wire unitTick    = usTick && usInUnit == 7'(SYNC_QUANT_US - 1);
    wire hundredTick = usTick && usInHundred == 7'(EMCY_UNIT_US - 1);
    wire msTick      = usTick && usInMs == 10'(MILLI_US - 1);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            usInUnit    <= 7'h0;
            usInHundred <= 7'h0;
            usInMs      <= 10'h0;
        end else if (usTick) begin
            usInUnit    <= unitTick ? 7'h0 : usInUnit + 7'h1;
            usInHundred <= hundredTick ? 7'h0 : usInHundred + 7'h1;
            usInMs      <= msTick ? 10'h0 : usInMs + 10'h1;
        end
    end

    // ------------------------------------------------------------
    // Sync production and window
    // ------------------------------------------------------------
    localparam logic [22:0] ACC_SAT = 23'h7f_ffff;
    wire [31:0] accNext  = {9'h0, accum} + 32'(SYNC_QUANT_US);
    wire        produce  = syncProducer && syncPeriod != 32'h0;
    wire        syncFire = produce && unitTick
                           && accNext >= syncPeriod;
    wire        syncSeen = syncFire || !syncProducer && syncRx;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            accum          <= ACC_SAT;
            syncTx         <= 1'b0;
            syncWindowOpen <= 1'b0;
        end else begin
            syncTx <= syncFire;
            if (syncSeen) begin
                accum <= 23'h0;
            end else if (unitTick && accum < ACC_SAT - 23'(SYNC_QUANT_US)) begin
                accum <= accNext[22:0];
            end
            syncWindowOpen <= {9'h0, accum} < syncWindow;
        end
    end

    // ------------------------------------------------------------
    // Emergency producer
    // ------------------------------------------------------------
    wire emcyOn   = !emcyId[BIT_DISABLE];
    wire gapDone  = emcyInhibit == 32'h0 || emcyGap >= emcyInhibit;
    wire emcySend = emcyPend && emcyOn && gapDone;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            emcyPend     <= 1'b0;
            emcyGap      <= 32'hffff_ffff;
            emcyTx       <= 1'b0;
            emcyExtended <= 1'b0;
            emcyCobId    <= 29'h0;
            timeConsume  <= 1'b0;
        end else begin
            emcyPend <= emcyReq || emcyPend && emcyOn && !emcySend;
            if (emcySend) begin
                emcyGap <= 32'h0;
            end else if (hundredTick && emcyGap != 32'hffff_ffff) begin
                emcyGap <= emcyGap + 32'h1;
            end
            emcyTx       <= emcySend;
            emcyExtended <= emcyId[BIT_EXTENDED];
            emcyCobId    <= emcyId[BIT_EXTENDED] ? emcyId[28:0]
                            : {18'h0, emcyId[10:0]};
            timeConsume  <= timeId[BIT_DISABLE];
        end
    end

    // ------------------------------------------------------------
    // Heartbeat producer
    // ------------------------------------------------------------
    wire hbStart = wrTo(IDX_HB_PRODUCER) && dictWdata[15:0] != 16'h0;
    wire hbDue   = msTick && hbPeriod != 16'h0
                   && hbCount + 16'h1 >= hbPeriod;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hbCount <= 16'h0;
            hbTx    <= 1'b0;
        end else begin
            hbTx <= hbStart || hbDue;
            if (hbStart || hbDue) begin
                hbCount <= 16'h0;
            end else if (msTick) begin
                hbCount <= hbCount + 16'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Heartbeat monitors
    // ------------------------------------------------------------
    for (genvar i = 0; i < MONITORS; i++) begin : g_mon
        wire [7:0] node   = hbEntry[i][23:16];
        wire [15:0] limit = hbEntry[i][15:0];
        wire       self   = isHbEntry && hbSel == 3'(i);
        wire       hit    = hbRxValid && node != 8'h0 && node == hbRxNode;
        wire       expire = hbMon[i] == HB_ACTIVE && limit != 16'h0
                            && msTick && hbTimer[i] <= 16'h1;
        assign dupHit[i] = !self && wNode != 8'h0 && node == wNode;
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                hbEntry[i]   <= 32'h0;
                hbTimer[i]   <= 16'h0;
                hbState[i]   <= 7'h0;
                hbMon[i]     <= HB_OFF;
                hbChanged[i] <= 1'b0;
                hbTimeout[i] <= 1'b0;
            end else begin
                hbChanged[i] <= hit && hbState[i] != hbRxState;
                hbTimeout[i] <= expire;
                if (wrOk && self) begin
                    hbEntry[i] <= dictWdata;
                    hbMon[i]   <= (wNode != 8'h0) ? HB_PENDING
                                  : HB_OFF;
                end else if (hit) begin
                    hbState[i] <= hbRxState;
                    hbTimer[i] <= limit;
                    hbMon[i]   <= HB_ACTIVE;
                end else if (expire) begin
                    hbMon[i] <= HB_EXPIRED;
                end else if (msTick && hbTimer[i] != 16'h0) begin
                    hbTimer[i] <= hbTimer[i] - 16'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    wire wrHbProd = wr && isIdx(IDX_HB_PRODUCER) && subZero;
    sequence s_idle8;
        !syncTx [*8];
    endsequence
    sync_zero_a: assert property (syncPeriod == 32'h0 |=> !syncTx)
        else $error("sync produced with zero period");
    sync_gap_a: assert property (syncTx |=> s_idle8)
        else $error("sync frames too close");
    preop_lock_a: assert property (wr && isIdx(IDX_SYNC_PERIOD)
        && !nmtPreOp |=> dictErr && $stable(syncPeriod))
        else $error("sync period written outside preop");
    guard_zero_a: assert property (dictReq && !dictWe
        && isIdx(IDX_GUARD_TIME) && subZero |=> dictRdata == 32'h0)
        else $error("guard time not zero");
    time_prod_a: assert property (wr && isIdx(IDX_TIME_ID)
        && dictWdata[BIT_PRODUCER] |=> dictErr && $stable(timeId))
        else $error("time producer accepted");
    stamp_step_a: assert property (usTick && !tsWrite
        |=> timeStamp == $past(timeStamp) + 32'h1)
        else $error("time stamp did not count");
    stamp_trim_a: assert property (tsWrite && tsSmall
        |=> timeStamp == $past(timeStamp)
            || timeStamp == $past(timeStamp) + 32'h1)
        else $error("small time write loaded");
    emcy_gate_a: assert property (emcyTx |-> $past(emcyOn))
        else $error("emergency sent while disabled");
    hb_dup_a: assert property (wr && isHbEntry && |dupHit
        |=> dictErr)
        else $error("duplicate monitor node accepted");
    hb_start_a: assert property (wrHbProd && nmtPreOp
        && dictWdata[15:0] != 16'h0 |=> hbTx)
        else $error("heartbeat did not start at once");
    ident_ro_a: assert property (wr && isIdx(IDX_IDENTITY)
        |=> dictErr)
        else $error("identity entry written");
endmodule : chb_objects
`default_nettype wire

/* hw/chb_pkg.sv */
// Constants and types for the communication-object services block
package chb_pkg;
    // ------------------------------------------------------------
    // Dictionary indices
    // ------------------------------------------------------------
    localparam logic [15:0] IDX_SYNC_PERIOD = 16'h1006;
    localparam logic [15:0] IDX_SYNC_WINDOW = 16'h1007;
    localparam logic [15:0] IDX_GUARD_TIME  = 16'h100c;
    localparam logic [15:0] IDX_LIFE_FACTOR = 16'h100d;
    localparam logic [15:0] IDX_TIME_ID     = 16'h1012;
    localparam logic [15:0] IDX_TIME_STAMP  = 16'h1013;
    localparam logic [15:0] IDX_EMCY_ID     = 16'h1014;
    localparam logic [15:0] IDX_EMCY_INHIB  = 16'h1015;
    localparam logic [15:0] IDX_HB_MONITOR  = 16'h1016;
    localparam logic [15:0] IDX_HB_PRODUCER = 16'h1017;
    localparam logic [15:0] IDX_IDENTITY    = 16'h1018;
    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int          BIT_DISABLE     = 31;
    localparam int          BIT_PRODUCER    = 30;
    localparam int          BIT_EXTENDED    = 29;
    localparam logic [31:0] TIME_ID_RESET   = 32'h0000_0100;
    localparam logic [7:0]  EMCY_ID_BASE    = 8'h80;
    localparam logic [7:0]  HB_MONITOR_NUM  = 8'h08;
    localparam logic [7:0]  IDENTITY_NUM    = 8'h04;
    localparam logic [31:0] PERIOD_MAX_US   = 32'd7864199;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int          CLK_PERIOD_NS   = 40;
    localparam int          MICRO_NS        = 1000;
    localparam int          CYC_PER_US      = MICRO_NS / CLK_PERIOD_NS;
    localparam int          SYNC_QUANT_US   = 120;
    localparam int          EMCY_UNIT_US    = 100;
    localparam int          MILLI_US        = 1000;
    localparam logic [31:0] TRIM_LIMIT_US   = 32'd1000;
    // ------------------------------------------------------------
    // Heartbeat monitor states, Gray along off-pending-active-expired
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        HB_OFF     = 2'b00,
        HB_PENDING = 2'b01,
        HB_ACTIVE  = 2'b11,
        HB_EXPIRED = 2'b10
    } chb_monitor_type;
endpackage : chb_pkg
